// *** common/fast_entry_pkg.sv ***
package fast_entry_pkg;

    // Model-specific register addresses
    localparam logic [31:0] MSR_CODE_SEL_ADDR = 32'h0000_0174;
    localparam logic [31:0] MSR_STACK_ADDR = 32'h0000_0175;
    localparam logic [31:0] MSR_POINTER_ADDR = 32'h0000_0176;

    // Reset values of the three registers
    localparam logic [63:0] CODE_SEL_RESET = 64'h0;
    localparam logic [63:0] STACK_RESET = 64'h0;
    localparam logic [63:0] POINTER_RESET = 64'h0;

    // Selector fields
    localparam logic [15:0] SEL_RPL_MASK = 16'hFFFC;
    localparam logic [15:0] STACK_SEL_STEP = 16'h0008;
    localparam int SEL_LO = 0;
    localparam int SEL_HI = 15;
    localparam int SEL_INDEX_LO = 2;

    // Fixed descriptor cache contents
    localparam logic [31:0] FLAT_BASE = 32'h0;
    localparam logic [19:0] FLAT_LIMIT = 20'hFFFFF;
    localparam logic [3:0] CODE_TYPE = 4'hB;
    localparam logic [3:0] STACK_TYPE = 4'h3;
    localparam logic [1:0] RING0 = 2'h0;
    localparam logic [1:0] CPL_RESET = 2'h3;

    // Canonical address width
    localparam int VADDR_BITS = 48;
    localparam int LOW_WORD_BITS = 32;

    // Fault error code
    localparam logic [15:0] GP_ERROR_CODE = 16'h0;

    // Identification instruction feature bit position in EDX
    localparam int PRESENT_BIT_POS = 11;

    // Descriptor cache layout
    typedef struct packed {
        logic [15:0] selector;
        logic [31:0] base;
        logic [19:0] limit;
        logic [3:0] segType;
        logic descS;
        logic [1:0] descriptor_privilege_level;
        logic present;
        logic longMode;
        logic defSize;
        logic gran;
    } seg_cache_type;

    // Processor mode inputs
    typedef struct packed {
        logic protEnable;
        logic ext64;
        logic lockPrefix;
    } cpu_mode_type;

    // Register write/read port
    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [31:0] addr;
        logic [63:0] data;
    } msr_req_type;

    // Fault kinds
    typedef enum logic [2:0] {
        FAULT_NONE = 3'b001,
        FAULT_GP = 3'b010,
        FAULT_UD = 3'b100
    } fault_type;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CHECK = 3'b010,
        ST_COMMIT = 3'b100
    } entry_state_type;

endpackage

// *** rtl/canonical_fix.sv ***
`timescale 1ns/1ps
// Forces an address canonical by sign-extending the top implemented bit
module canonical_fix #(
    parameter int ADDR_BITS = fast_entry_pkg::VADDR_BITS
) (
    input wire logic [63:0] rawAddr,
    output logic [63:0] canonAddr
);
    import fast_entry_pkg::*;

    // Each upper bit copies the sign bit; lower bits pass through
    genvar i;
    generate
        for (i = 0; i < 64; i++) begin : gen_bit
            if (i < ADDR_BITS) begin : gen_keep
                assign canonAddr[i] = rawAddr[i];
            end else begin : gen_ext
                assign canonAddr[i] = rawAddr[ADDR_BITS-1];
            end
        end
    endgenerate
endmodule

// *** rtl/entry_fault_check.sv ***
`timescale 1ns/1ps
// Entry precondition checks, purely combinational
module entry_fault_check (
    input wire fast_entry_pkg::cpu_mode_type mode,
    input wire logic [63:0] codeSel,
    output fast_entry_pkg::fault_type fault
);
    import fast_entry_pkg::*;

    logic nullSel; // Selector index and table bits all zero

    // Lock prefix outranks the protection checks
    always_comb begin
        nullSel = (codeSel[SEL_HI:SEL_INDEX_LO] == '0);
        if (mode.lockPrefix) begin
            fault = FAULT_UD;
        end else if (!mode.protEnable || nullSel) begin
            // Real mode lands here too; same test in every other mode
            fault = FAULT_GP;
        end else begin
            fault = FAULT_NONE;
        end
    end
endmodule

// *** rtl/fast_system_call_entry.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - GP fault(0) if protection off or null selector
// - Successful entry clears virtual-8086 and interrupt flags
// - Pointer full in 64-bit, else low 32
// - Stack full in 64-bit, else low 32
// - Code selector is register low bits AND FFFC
// - Code cache loaded with fixed flat values
// - Long/default-size bits follow extended 64-bit mode
// - Privilege level becomes zero on entry
// - Stack selector equals code selector plus eight
// - Stack cache loaded with fixed flat values
// - No return state saved, no stack parameters
// - Lock prefix raises invalid opcode fault
// - Real-address mode raises GP fault
// - Same checks in all non-real modes
// - Extended mode enters 64-bit, else protected
// - Pointer and stack registers always canonical
// - Presence bit reported for identification instruction
module fast_system_call_entry #(
    parameter int ADDR_BITS = fast_entry_pkg::VADDR_BITS
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic entryReq,
    input wire fast_entry_pkg::cpu_mode_type mode,
    input wire fast_entry_pkg::msr_req_type msrReq,
    output logic [63:0] msrRdData,
    output logic msrRdValid,
    output logic msrAddrErr,
    output logic entryDone,
    output logic gpFault,
    output logic udFault,
    output logic [15:0] faultCode,
    output logic [63:0] instrPtr,
    output logic [63:0] stackPtr,
    output fast_entry_pkg::seg_cache_type codeSeg,
    output fast_entry_pkg::seg_cache_type stackSeg,
    output logic [1:0] current_privilege_level,
    output logic clearVm,
    output logic clearIf,
    output logic in64Mode,
    output logic fetchRedirect,
    output logic presentBit
);
    import fast_entry_pkg::*;

    // Register storage
    logic [63:0] codeSel_reg; // Code selector register
    logic [63:0] stack_reg; // Entry stack register
    logic [63:0] pointer_reg; // Entry pointer register
    logic [63:0] canonWr; // Canonical form of written data
    // Entry path
    entry_state_type state_reg; // Entry sequencer
    entry_state_type state_next;
    cpu_mode_type modeLatch_reg; // Mode captured at request
    fault_type faultKind; // Checker verdict
    logic [15:0] newCodeSel; // Derived code selector
    logic [63:0] ptrSel; // Width-selected pointer
    logic [63:0] stkSel; // Width-selected stack
    logic commitNow; // Successful entry in this enabled edge

    // Pointer and stack write data forced canonical before it is stored
    // Upper bits follow the top implemented bit, so no bad value is ever held
    canonical_fix #(
        .ADDR_BITS(ADDR_BITS)
    ) u_canon (
        .rawAddr(msrReq.data),
        .canonAddr(canonWr)
    );

    // Fault verdict uses the captured mode and the live selector
    // Selector is read live, so a write taken with the request still counts; one taken on leaving the check state does not
    entry_fault_check u_check (
        .mode(modeLatch_reg),
        .codeSel(codeSel_reg),
        .fault(faultKind)
    );

    // Register writes; pointer and stack only ever hold canonical values
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            // All three registers start at zero
            codeSel_reg <= CODE_SEL_RESET;
            stack_reg <= STACK_RESET;
            pointer_reg <= POINTER_RESET;
        end else if (clkEn && msrReq.wrEn) begin
            case (msrReq.addr)
                // Selector kept whole; entry only uses the low half-word
                MSR_CODE_SEL_ADDR: begin
                    codeSel_reg <= msrReq.data;
                end
                // Stack value stored in canonical form
                MSR_STACK_ADDR: begin
                    stack_reg <= canonWr;
                end
                // Pointer value stored in canonical form
                MSR_POINTER_ADDR: begin
                    pointer_reg <= canonWr;
                end
                default: begin
                    // Unmapped address: nothing stored
                end
            endcase
        end
    end

    // Register reads, one cycle after the request
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            // Nothing valid out of reset
            msrRdData <= 64'h0;
            msrRdValid <= 1'b0;
            msrAddrErr <= 1'b0;
        end else if (clkEn) begin
            msrRdValid <= msrReq.rdEn;
            msrAddrErr <= 1'b0;
            // Both strobes together both act; the read sees the old value
            if (msrReq.rdEn) begin
                case (msrReq.addr)
                    MSR_CODE_SEL_ADDR: msrRdData <= codeSel_reg;
                    MSR_STACK_ADDR: msrRdData <= stack_reg;
                    MSR_POINTER_ADDR: msrRdData <= pointer_reg;
                    default: begin
                        // Unmapped read answers zero and flags an error
                        msrRdData <= 64'h0;
                        msrAddrErr <= 1'b1;
                    end
                endcase
            end else if (msrReq.wrEn) begin
                // Write to an unmapped place only raises the error pulse
                msrAddrErr <= !(msrReq.addr inside
                    {MSR_CODE_SEL_ADDR, MSR_STACK_ADDR, MSR_POINTER_ADDR});
            end
        end
    end

    // Sequencer: capture, check, commit
    always_comb begin
        case (state_reg)
            // Waiting; a request moves on to the check step
            ST_IDLE: state_next = entryReq ? ST_CHECK : ST_IDLE;
            // Verdict and commit happen on leaving this state
            ST_CHECK: state_next = ST_COMMIT;
            // Answer stands on the outputs; requests here are ignored
            ST_COMMIT: state_next = ST_IDLE;
            // Illegal code falls back to idle
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
        end else if (clkEn) begin
            // Frozen with everything else while the enable is low
            state_reg <= state_next;
        end
    end

    // Mode captured with the request so a change mid-entry cannot tear it
    // Mode bits away from the take edge are ignored
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            modeLatch_reg <= '0;
        end else if (clkEn && state_reg == ST_IDLE && entryReq) begin
            modeLatch_reg <= mode;
        end
    end

    // Selector and width selection
    always_comb begin
        newCodeSel = codeSel_reg[SEL_HI:SEL_LO] & SEL_RPL_MASK;
        if (modeLatch_reg.ext64) begin
            // Full register width in extended mode
            ptrSel = pointer_reg;
            stkSel = stack_reg;
        end else begin
            // Upper half reads as zero outside extended mode
            ptrSel = {{(64-LOW_WORD_BITS){1'b0}}, pointer_reg[LOW_WORD_BITS-1:0]};
            stkSel = {{(64-LOW_WORD_BITS){1'b0}}, stack_reg[LOW_WORD_BITS-1:0]};
        end
    end

    // Fault outputs, pulsed one cycle in the commit state
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            gpFault <= 1'b0;
            udFault <= 1'b0;
            faultCode <= GP_ERROR_CODE;
        end else if (clkEn) begin
            // Lock prefix is already ranked first by the checker
            gpFault <= (state_reg == ST_CHECK) && (faultKind == FAULT_GP);
            udFault <= (state_reg == ST_CHECK) && (faultKind == FAULT_UD);
            faultCode <= GP_ERROR_CODE;
        end
    end

    // Success strobe shared by the pointer, cache and privilege processes, so those fields move together
    assign commitNow = clkEn && (state_reg == ST_CHECK) && (faultKind == FAULT_NONE);

    // Pointer load; nothing is pushed or saved, so the caller's pointer is lost
    // Software has to keep its own return point before entering
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            instrPtr <= 64'h0;
            stackPtr <= 64'h0;
        end else if (commitNow) begin
            // Width already chosen from the mode taken with the request
            instrPtr <= ptrSel;
            stackPtr <= stkSel;
        end
    end

    // Code cache: fixed contents, descriptor tables are never fetched
    // Trade-off: no table walk, so a stale descriptor in memory goes unnoticed
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            codeSeg <= '0;
        end else if (commitNow) begin
            // Selector from the register with the requested field cleared
            codeSeg.selector <= newCodeSel;
            // Zero base and full limit cover the whole space
            codeSeg.base <= FLAT_BASE;
            codeSeg.limit <= FLAT_LIMIT;
            // Execute/read, accessed, ring 0, present
            codeSeg.segType <= CODE_TYPE;
            codeSeg.descS <= 1'b1;
            codeSeg.descriptor_privilege_level <= RING0;
            codeSeg.present <= 1'b1;
            // Long and default-size bits are exclusive
            codeSeg.longMode <= modeLatch_reg.ext64;
            codeSeg.defSize <= !modeLatch_reg.ext64;
            // Page granularity stretches the limit
            codeSeg.gran <= 1'b1;
        end
    end

    // Stack cache: fixed contents, selector one descriptor above the code
    // Relies on software keeping the two descriptors side by side
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stackSeg <= '0;
        end else if (commitNow) begin
            // Next descriptor slot after the code selector
            stackSeg.selector <= newCodeSel + STACK_SEL_STEP;
            // Zero base and full limit cover the whole space
            stackSeg.base <= FLAT_BASE;
            stackSeg.limit <= FLAT_LIMIT;
            // Read/write data, accessed, ring 0, present
            stackSeg.segType <= STACK_TYPE;
            stackSeg.descS <= 1'b1;
            stackSeg.descriptor_privilege_level <= RING0;
            stackSeg.present <= 1'b1;
            // Never a long segment; the big bit gives a 32-bit stack
            stackSeg.longMode <= 1'b0;
            stackSeg.defSize <= 1'b1;
            // Page granularity stretches the limit
            stackSeg.gran <= 1'b1;
        end
    end

    // Privilege and execution mode; user level until the first entry
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            current_privilege_level <= CPL_RESET;
            in64Mode <= 1'b0;
        end else if (commitNow) begin
            current_privilege_level <= RING0;
            // Extended mode lands in 64-bit code, otherwise protected mode stays
            in64Mode <= modeLatch_reg.ext64;
        end
    end

    // Completion pulses: flag clears and fetch redirect ride with commit
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            entryDone <= 1'b0;
            clearVm <= 1'b0;
            clearIf <= 1'b0;
            fetchRedirect <= 1'b0;
        end else if (clkEn) begin
            // One-cycle commands; the flag registers live elsewhere in the core
            entryDone <= (state_reg == ST_CHECK) && (faultKind == FAULT_NONE);
            clearVm <= (state_reg == ST_CHECK) && (faultKind == FAULT_NONE);
            clearIf <= (state_reg == ST_CHECK) && (faultKind == FAULT_NONE);
            fetchRedirect <= (state_reg == ST_CHECK) && (faultKind == FAULT_NONE);
        end
    end

    // Feature presence for the identification instruction, set once out of reset
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            presentBit <= 1'b0;
        end else if (clkEn) begin
            // Bit stands once out of reset; its slot in the result is a constant
            presentBit <= 1'b1;
        end
    end

endmodule

// *** dv/fast_system_call_entry_asserts.sv ***
`timescale 1ns/1ps
// Watches entry outcomes at the top ports
module fast_system_call_entry_asserts (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic entryReq,
    input wire fast_entry_pkg::cpu_mode_type mode,
    input wire logic entryDone,
    input wire logic gpFault,
    input wire logic udFault,
    input wire logic [15:0] faultCode,
    input wire logic [63:0] instrPtr,
    input wire logic [63:0] stackPtr,
    input wire fast_entry_pkg::seg_cache_type codeSeg,
    input wire fast_entry_pkg::seg_cache_type stackSeg,
    input wire logic [1:0] current_privilege_level,
    input wire logic clearVm,
    input wire logic clearIf,
    input wire logic in64Mode
);
    import fast_entry_pkg::*;
    // One domain, so one default clock and reset
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    // Request with a lock prefix
    sequence s_lock;
        clkEn && entryReq && mode.lockPrefix;
    endsequence
    // Unlocked request with protection off
    sequence s_noprot;
        clkEn && entryReq && !mode.lockPrefix && !mode.protEnable;
    endsequence
    // Answer is checked two clock edges after the take, one edge after it lands
    property p_ud;
        s_lock |-> ##2 udFault && !gpFault && !entryDone;
    endproperty
    a_ud: assert property (p_ud) else $error("lock prefix not refused");
    property p_gp;
        s_noprot |-> ##2 gpFault && !entryDone && faultCode == GP_ERROR_CODE;
    endproperty
    a_gp: assert property (p_gp) else $error("real mode entry not refused");
    property p_flags;
        entryDone |-> clearVm && clearIf && current_privilege_level == RING0;
    endproperty
    a_flags: assert property (p_flags) else $error("flags or level wrong");
    property p_cs;
        entryDone |-> codeSeg.base == FLAT_BASE && codeSeg.limit == FLAT_LIMIT
            && codeSeg.segType == CODE_TYPE && codeSeg.descS && codeSeg.descriptor_privilege_level == RING0
            && codeSeg.present && codeSeg.gran;
    endproperty
    a_cs: assert property (p_cs) else $error("code cache wrong");
    property p_ss;
        entryDone |-> stackSeg.base == FLAT_BASE && stackSeg.limit == FLAT_LIMIT
            && stackSeg.segType == STACK_TYPE && stackSeg.descS && stackSeg.descriptor_privilege_level == RING0
            && stackSeg.present && stackSeg.defSize && stackSeg.gran;
    endproperty
    a_ss: assert property (p_ss) else $error("stack cache wrong");
    property p_sel;
        entryDone |-> stackSeg.selector == codeSeg.selector + STACK_SEL_STEP
            && codeSeg.selector[1:0] == 2'h0;
    endproperty
    a_sel: assert property (p_sel) else $error("selectors wrong");
    property p_long;
        entryDone |-> codeSeg.longMode == in64Mode && codeSeg.defSize == !in64Mode;
    endproperty
    a_long: assert property (p_long) else $error("long bits wrong");
    property p_ptr;
        entryDone && !in64Mode |-> instrPtr[63:32] == 32'h0 && stackPtr[63:32] == 32'h0;
    endproperty
    a_ptr: assert property (p_ptr) else $error("pointer not truncated");
    // A refused entry leaves both pointers, the privilege level and both caches where they were
    property p_hold;
        gpFault || udFault |-> $stable(instrPtr) && $stable(stackPtr) && $stable(current_privilege_level)
            && $stable(codeSeg) && $stable(stackSeg);
    endproperty
    a_hold: assert property (p_hold) else $error("state moved on a fault");
endmodule

// *** dv/fast_system_call_entry_tb.sv ***
`timescale 1ns/1ps
// Register accesses and entries through the block's own ports
module fast_system_call_entry_tb;
    import fast_entry_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic clkEn = 1'b1;
    logic entryReq = 1'b0;
    cpu_mode_type mode = '0;
    msr_req_type msrReq = '0;
    logic [63:0] msrRdData, instrPtr, stackPtr;
    logic msrRdValid, msrAddrErr, entryDone, gpFault, udFault;
    logic clearVm, clearIf, in64Mode, fetchRedirect, presentBit;
    logic [15:0] faultCode;
    logic [1:0] current_privilege_level;
    seg_cache_type codeSeg, stackSeg;
    int nErrors = 0;
    int nCompared = 0;
    // 250 MHz core clock
    always #2 ref_clk = ~ref_clk;
    fast_system_call_entry u_fast_system_call_entry (
        .ref_clk(ref_clk), .rst(rst), .clkEn(clkEn), .entryReq(entryReq), .mode(mode),
        .msrReq(msrReq), .msrRdData(msrRdData), .msrRdValid(msrRdValid),
        .msrAddrErr(msrAddrErr), .entryDone(entryDone), .gpFault(gpFault),
        .udFault(udFault), .faultCode(faultCode), .instrPtr(instrPtr),
        .stackPtr(stackPtr), .codeSeg(codeSeg), .stackSeg(stackSeg), .current_privilege_level(current_privilege_level),
        .clearVm(clearVm), .clearIf(clearIf), .in64Mode(in64Mode),
        .fetchRedirect(fetchRedirect), .presentBit(presentBit));
    // Verdict in one place
    task conclude;
        $display("errors %0d compared %0d", nErrors, nCompared);
        if (nErrors == 0 && nCompared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Four-state compare
    task chk(input logic [63:0] got, input logic [63:0] exp);
        nCompared++;
        if (got !== exp) begin
            nErrors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One-cycle write, taken at the next edge
    task wr(input logic [31:0] a, input logic [63:0] d);
        @(negedge ref_clk);
        msrReq = '{1'b1, 1'b0, a, d};
        @(negedge ref_clk);
        msrReq = '0;
    endtask
    // Read; answer stands one cycle after the take
    task rd(input logic [31:0] a, input logic [63:0] e);
        @(negedge ref_clk);
        msrReq = '{1'b0, 1'b1, a, 64'h0};
        @(negedge ref_clk);
        msrReq = '0;
        chk({63'h0, msrRdValid}, 64'h1);
        chk(msrRdData, e);
    endtask
    // Entry; k is {done, gp, ud}, looked at in the one cycle the answer stands
    task ent(input logic pe, input logic x, input logic lk, input logic [2:0] k);
        @(negedge ref_clk);
        entryReq = 1'b1;
        mode = '{pe, x, lk};
        @(negedge ref_clk);
        entryReq = 1'b0;
        @(negedge ref_clk);
        chk({58'h0, fetchRedirect, clearVm, clearIf, entryDone, gpFault, udFault},
            {58'h0, k[2], k[2], k[2], k});
    endtask
    // State left by the last successful entry
    task post(input logic [63:0] ip, input logic [63:0] sp, input logic [15:0] cs,
              input logic l);
        chk(instrPtr, ip);
        chk(stackPtr, sp);
        chk({29'h0, codeSeg.selector, stackSeg.selector, current_privilege_level, in64Mode},
            {29'h0, cs, cs + STACK_SEL_STEP, RING0, l});
        chk({62'h0, codeSeg.longMode, codeSeg.defSize}, {62'h0, l, !l});
    endtask
    // Hang guard
    initial begin
        repeat (5000) @(posedge ref_clk);
        nErrors++;
        conclude();
    end
    // Main sequence
    initial begin
        repeat (10) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        rd(MSR_CODE_SEL_ADDR, CODE_SEL_RESET);
        rd(MSR_STACK_ADDR, STACK_RESET);
        rd(MSR_POINTER_ADDR, POINTER_RESET);
        chk({61'h0, presentBit, current_privilege_level}, 64'h7);
        // Unmapped place reads zero and flags it
        rd(32'h0000_0177, 64'h0);
        chk({63'h0, msrAddrErr}, 64'h1);
        // Enable low freezes the register port
        @(negedge ref_clk);
        clkEn = 1'b0;
        msrReq = '{1'b0, 1'b1, MSR_CODE_SEL_ADDR, 64'h0};
        @(negedge ref_clk);
        chk({63'h0, msrRdValid}, 64'h0);
        msrReq = '0;
        clkEn = 1'b1;
        // Upper bits set so only the low half-word may count
        wr(MSR_CODE_SEL_ADDR, 64'hFFFF_0000_0000_0003);
        wr(MSR_POINTER_ADDR, 64'hFFFF_8000_1234_5678);
        wr(MSR_STACK_ADDR, 64'h0000_9000_0000_1000);
        // Unmapped write flags itself and must not land anywhere
        wr(32'h0000_0177, 64'hFFFF_FFFF_FFFF_FFFF);
        chk({63'h0, msrAddrErr}, 64'h1);
        rd(MSR_STACK_ADDR, 64'hFFFF_9000_0000_1000);
        rd(MSR_POINTER_ADDR, 64'hFFFF_8000_1234_5678);
        ent(1'b1, 1'b0, 1'b1, 3'b001);
        ent(1'b0, 1'b1, 1'b1, 3'b001);
        ent(1'b0, 1'b0, 1'b0, 3'b010);
        ent(1'b1, 1'b0, 1'b0, 3'b010);
        ent(1'b1, 1'b1, 1'b0, 3'b010);
        chk({62'h0, current_privilege_level}, 64'h3);
        // Index zero with the table bit set, requested field set
        wr(MSR_CODE_SEL_ADDR, 64'hFFFF_0000_0000_0007);
        ent(1'b1, 1'b0, 1'b0, 3'b100);
        post(64'h1234_5678, 64'h1000, 16'h0004, 1'b0);
        wr(MSR_CODE_SEL_ADDR, 64'h0000_0000_0000_ABCF);
        ent(1'b1, 1'b1, 1'b0, 3'b100);
        post(64'hFFFF_8000_1234_5678, 64'hFFFF_9000_0000_1000, 16'hABCC, 1'b1);
        // A fault straight after success leaves the state alone
        ent(1'b1, 1'b0, 1'b1, 3'b001);
        post(64'hFFFF_8000_1234_5678, 64'hFFFF_9000_0000_1000, 16'hABCC, 1'b1);
        // Reset in mid-run restores user level
        @(negedge ref_clk);
        rst = 1'b1;
        @(negedge ref_clk);
        chk({61'h0, presentBit, current_privilege_level}, 64'h3);
        chk(instrPtr, 64'h0);
        rst = 1'b0;
        @(negedge ref_clk);
        chk({61'h0, presentBit, current_privilege_level}, 64'h7);
        conclude();
    end
endmodule
bind fast_system_call_entry fast_system_call_entry_asserts u_chk (
    .ref_clk(ref_clk), .rst(rst), .clkEn(clkEn), .entryReq(entryReq), .mode(mode),
    .entryDone(entryDone), .gpFault(gpFault), .udFault(udFault), .faultCode(faultCode),
    .instrPtr(instrPtr), .stackPtr(stackPtr), .codeSeg(codeSeg), .stackSeg(stackSeg),
    .current_privilege_level(current_privilege_level), .clearVm(clearVm), .clearIf(clearIf), .in64Mode(in64Mode));
